// >>> hdl/rxc_pkg.sv
// shared constants and carrier types of the wireless receiver charge controller
`default_nettype none
package rxc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int BIT_RATE_BPS = 2000;
  localparam int HALF_BIT_CYC = CLK_HZ / BIT_RATE_BPS / 2;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam int CE_SLOW_MS = 250;
  localparam int CE_FAST_MS = 30;
  localparam int PRE_TIMEOUT_MS = 1_800_000;
  localparam int CONV_TRIES = 8;
  // ---------------------------------------------------------------
  // packet framing and codes
  // ---------------------------------------------------------------
  localparam int BITS_PER_SLOT = 11;
  localparam int SLOTS = 4;
  localparam logic [7:0] HDR_SS = 8'h01;
  localparam logic [7:0] HDR_EPT = 8'h02;
  localparam logic [7:0] HDR_CE = 8'h03;
  localparam logic [7:0] HDR_FULL = 8'h05;
  localparam logic [7:0] HDR_CFG = 8'h51;
  localparam logic [7:0] HDR_ID = 8'h71;
  localparam logic [7:0] SS_VALUE = 8'hff;
  localparam logic [7:0] CFG_VALUE = 8'h0a;
  localparam logic [7:0] ID_VALUE = 8'h5a; // arbitrary value
  localparam logic [7:0] FULL_VALUE = 8'h64;
  localparam logic [7:0] CE_UP = 8'h14;
  localparam logic [7:0] CE_DOWN = 8'hec;
  localparam logic [7:0] CE_DOWN_MAX = 8'h80;
  localparam logic [7:0] CE_HOLD = 8'h00;
  localparam logic [7:0] EPT_WIRED = 8'h00;
  localparam logic [7:0] EPT_CTRL_HIGH = 8'h01;
  localparam logic [7:0] EPT_INTERNAL = 8'h02;
  localparam logic [7:0] EPT_THERMISTOR = 8'h03;
  localparam logic [7:0] EPT_PRE_TIMEOUT = 8'h06;
  localparam logic [7:0] EPT_NO_CONVERGE = 8'h08;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FULL_OHMS = 4'h1;
  localparam logic [3:0] REG_LINK = 4'h2;
  localparam logic [3:0] REG_PHASE = 4'h3;
  localparam int CTRL_INHIBIT_BIT = 7;
  localparam logic [6:0] FULL_PCT_RESET = 7'h0a;
  localparam logic [15:0] FULL_THRESHOLD_SCALE = 16'h00f0;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ping; logic src_off; logic ad_present; logic ctrl_high; logic ctrl_low;
    logic die_hot; logic die_fault; logic bat_short; logic bat_low; logic bat_reg;
    logic i_term; logic i_taper35; logic i_full; logic rect_7v; logic rect_high;
    logic rect_low; logic rect_jump; logic ovp; logic ts_z12; logic ts_z23;
    logic ts_z34; logic ts_ok;
  } rxc_sense_type;
  typedef enum logic [2:0] {C_OFF = 3'h0, C_SHORT = 3'h1, C_PRE = 3'h2, C_FULL = 3'h3,
    C_HALF = 3'h4} rxc_cur_type;
  typedef enum logic [1:0] {V_NORM = 2'h0, V_425 = 2'h1, V_410 = 2'h2} rxc_vcap_type;
  typedef enum logic [1:0] {R_TRACK = 2'h0, R_FIXED = 2'h1, R_7V = 2'h2} rxc_rect_type;
  typedef struct packed {
    logic out_en; logic pass_off; logic hiz; logic cur_reduce;
    rxc_cur_type cur_sel; rxc_vcap_type vcap; rxc_rect_type rect_mode;
  } rxc_drive_type;
endpackage
`default_nettype wire

// >>> hdl/rxc_top.sv
// wireless receiver link sequencer, packet modulator and charge phase controller
//
// Operation
// - after extended ping send signal strength, configuration, identification first, in order
// - shutdown condition at startup ends power transfer at once
// - ask rectifier above 7 V before enabling output supply
// - rectifier target from output current fraction; error packets until converged
// - each main loop pass checks stop conditions and ends transfer
// - above precharge threshold, rectifier tracks battery plus 300 mV
// - below precharge threshold or taper under 35 percent: fixed rectifier level
// - at or below precharge threshold: precharge at 20 percent current
// - below short threshold short recovery current, above it precharge current
// - above precharge threshold: constant current fast charge
// - at regulation voltage: constant voltage phase while current tapers
// - below taper cutoff current: output goes high impedance
// - die over temperature reduces charge current in every phase except suspend and termination
// - at full threshold send full status packet 0x05, transfer continues
// - full threshold is percent of bulk program, scale 240 per percent
// - charge only while thermistor between edges one and four, else suspend
// - zone 1-2 half current; 2-3 cap 4.25V; 3-4 cap 4.10V, half current
// - after rectifier jump error packets every 30ms, then every 250ms
// - overvoltage: pass transistor off, ask rectifier down to regulation level
// - packets by load modulation, differential biphase at 2 kbit/s
// - end transfer packet 0x02 carries its reason code
// - charging indicator active whenever output enabled, never before convergence
//
// Local design decisions: the placing of the registers and strobed register access.
`default_nettype none
module rxc_top
  import rxc_pkg::*;
#(
  parameter int HALF_BIT_CYCLES = HALF_BIT_CYC,
  parameter int MS_CYCLES = MS_CYC,
  parameter int PRE_TIMEOUT = PRE_TIMEOUT_MS
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire rxc_sense_type sense_in,
  output rxc_drive_type drive,
  output logic [15:0] full_ohms,
  output logic mod_out,
  input wire logic chg_in,
  output logic chg_out,
  output logic chg_oe
);
  // ---------------------------------------------------------------
  // checks and types
  // ---------------------------------------------------------------
  if (HALF_BIT_CYCLES < 2 || MS_CYCLES < 2 || PRE_TIMEOUT < 1 || PRE_TIMEOUT > 2097151)
  begin : g_bad
    $error("rxc_top: unsupported timing parameter");
  end

  typedef enum logic [7:0] {L_IDLE = 8'h01, L_SS = 8'h02, L_CFG = 8'h04, L_ID = 8'h08,
    L_RAMP = 8'h10, L_MAIN = 8'h20, L_EPT = 8'h40, L_DONE = 8'h80} rxc_link_type;
  typedef enum logic [5:0] {P_SHORT = 6'h01, P_PRE = 6'h02, P_FAST = 6'h04, P_CV = 6'h08,
    P_TERM = 6'h10, P_SUSP = 6'h20} rxc_phase_type;

  // stop reason: bit 8 valid, low byte reason code
  function automatic logic [8:0] stop_code(input rxc_sense_type s, input logic pto);
    logic [8:0] c;
    c = 9'h000;
    if (s.ad_present || s.src_off) c = {1'b1, EPT_WIRED};
    else if (s.ctrl_high) c = {1'b1, EPT_CTRL_HIGH};
    else if (s.die_fault) c = {1'b1, EPT_INTERNAL};
    else if (s.ctrl_low) c = {1'b1, EPT_THERMISTOR};
    else if (pto) c = {1'b1, EPT_PRE_TIMEOUT};
    return c;
  endfunction

  // ---------------------------------------------------------------
  // input synchroniser, three stages
  // ---------------------------------------------------------------
  rxc_sense_type s1_q, s2_q, s3_q, sense;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sense <= '0;
    end
    else
    begin
      s1_q <= sense_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a bit moves only once stages two and three agree
      sense <= (s2_q & s3_q) | (sense & (s2_q | s3_q));
    end
  end

  // indicator pad, same filter; resets to the pulled-up idle level
  logic [2:0] chg_sync_q;
  logic chg_pin_q;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      chg_sync_q <= 3'h7;
      chg_pin_q <= 1'b1;
    end
    else
    begin
      chg_sync_q <= {chg_sync_q[1:0], chg_in};
      if (chg_sync_q[1] == chg_sync_q[2])
        chg_pin_q <= chg_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [6:0] full_pct_q;
  logic inhibit_q;
  rxc_link_type link_q;
  rxc_phase_type phase_q, phase_d;
  logic [7:0] reason_q;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      full_pct_q <= FULL_PCT_RESET;
      inhibit_q <= 1'b0;
    end
    else if (wr_en && addr == REG_CTRL)
    begin
      full_pct_q <= wdata[6:0];
      inhibit_q <= wdata[CTRL_INHIBIT_BIT];
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata <= 16'h0000;
    else if (rd_en)
      case (addr)
        REG_CTRL: rdata <= {8'h00, inhibit_q, full_pct_q};
        REG_FULL_OHMS: rdata <= full_ohms;
        REG_LINK: rdata <= {reason_q, link_q};
        REG_PHASE: rdata <= {9'h000, chg_pin_q, phase_q};
        default: rdata <= 16'h0000;
      endcase
    else
      rdata <= 16'h0000;
  end

  // analog trim code of the full threshold
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      full_ohms <= 16'h0000;
    else
      full_ohms <= 16'({9'h000, full_pct_q} * FULL_THRESHOLD_SCALE);
  end

  // ---------------------------------------------------------------
  // millisecond timers
  // ---------------------------------------------------------------
  logic [$clog2(MS_CYCLES)-1:0] pre_cnt_q;
  logic ms_tick;
  logic [7:0] ce_ms_q;
  logic [20:0] pre_ms_q;
  logic jump_q, ce_due, ce_fast_due, pre_timeout, ce_sent, converged;
  logic tx_go_q, tx_act_q, tx_busy;
  logic [7:0] tx_hdr_q, tx_dat_q;
  assign ms_tick = (pre_cnt_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  assign converged = !sense.rect_high && !sense.rect_low;
  assign ce_sent = tx_go_q && tx_hdr_q == HDR_CE;
  assign ce_fast_due = ce_ms_q >= 8'(CE_FAST_MS);
  assign ce_due = (jump_q || sense.ovp) ? ce_fast_due : (ce_ms_q >= 8'(CE_SLOW_MS));
  assign pre_timeout = pre_ms_q >= 21'(PRE_TIMEOUT);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pre_cnt_q <= '0;
    else
      pre_cnt_q <= ms_tick ? '0 : pre_cnt_q + 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ce_ms_q <= 8'h00;
    else if (ce_sent)
      ce_ms_q <= 8'h00;
    else if (ms_tick && ce_ms_q != 8'hff)
      ce_ms_q <= ce_ms_q + 8'h01;
  end

  // jump flag: a new jump beats the clear in the same cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      jump_q <= 1'b0;
    else if (sense.rect_jump && link_q == L_MAIN)
      jump_q <= 1'b1;
    else if (converged)
      jump_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pre_ms_q <= 21'h000000;
    else if (phase_q != P_PRE && phase_q != P_SHORT)
      pre_ms_q <= 21'h000000;
    else if (ms_tick && !pre_timeout)
      pre_ms_q <= pre_ms_q + 21'h000001;
  end

  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  logic out_en_q, full_sent_q;
  logic [3:0] tries_q;
  logic [8:0] stop;
  assign stop = stop_code(sense, pre_timeout);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      link_q <= L_IDLE;
      tx_go_q <= 1'b0;
      tx_hdr_q <= 8'h00;
      tx_dat_q <= 8'h00;
      out_en_q <= 1'b0;
      full_sent_q <= 1'b0;
      tries_q <= 4'h0;
      reason_q <= 8'h00;
    end
    else
    begin
      tx_go_q <= 1'b0;
      if (!sense.ping)
      begin
        link_q <= L_IDLE;
        out_en_q <= 1'b0;
        full_sent_q <= 1'b0;
      end
      else
        case (link_q)
          L_IDLE:
          begin
            tries_q <= 4'h0;
            tx_go_q <= 1'b1;
            if (stop_code(sense, 1'b0) != 9'h000)
            begin
              tx_hdr_q <= HDR_EPT;
              tx_dat_q <= stop[7:0];
              reason_q <= stop[7:0];
              link_q <= L_EPT;
            end
            else
            begin
              tx_hdr_q <= HDR_SS;
              tx_dat_q <= SS_VALUE;
              link_q <= L_SS;
            end
          end
          L_SS, L_CFG:
            if (!tx_busy)
            begin
              tx_go_q <= 1'b1;
              tx_hdr_q <= (link_q == L_SS) ? HDR_CFG : HDR_ID;
              tx_dat_q <= (link_q == L_SS) ? CFG_VALUE : ID_VALUE;
              link_q <= (link_q == L_SS) ? L_CFG : L_ID;
            end
          L_ID:
            if (!tx_busy)
              link_q <= L_RAMP;
          L_RAMP:
            if (!tx_busy)
            begin
              if (stop != 9'h000 || tries_q == 4'(CONV_TRIES))
              begin
                tx_go_q <= 1'b1;
                tx_hdr_q <= HDR_EPT;
                tx_dat_q <= (stop != 9'h000) ? stop[7:0] : EPT_NO_CONVERGE;
                reason_q <= (stop != 9'h000) ? stop[7:0] : EPT_NO_CONVERGE;
                link_q <= L_EPT;
              end
              else if (sense.rect_7v)
              begin
                out_en_q <= 1'b1;
                link_q <= L_MAIN;
              end
              else if (ce_fast_due)
              begin
                tx_go_q <= 1'b1;
                tx_hdr_q <= HDR_CE;
                tx_dat_q <= CE_UP;
                tries_q <= tries_q + 4'h1;
              end
            end
          L_MAIN:
            if (!tx_busy)
            begin
              if (stop != 9'h000)
              begin
                tx_go_q <= 1'b1;
                tx_hdr_q <= HDR_EPT;
                tx_dat_q <= stop[7:0];
                reason_q <= stop[7:0];
                link_q <= L_EPT;
              end
              else if (sense.i_full && !full_sent_q)
              begin
                tx_go_q <= 1'b1;
                tx_hdr_q <= HDR_FULL;
                tx_dat_q <= FULL_VALUE;
                full_sent_q <= 1'b1;
              end
              else if (ce_due)
              begin
                tx_go_q <= 1'b1;
                tx_hdr_q <= HDR_CE;
                if (sense.ovp)
                  tx_dat_q <= CE_DOWN_MAX;
                else if (sense.rect_high)
                  tx_dat_q <= CE_DOWN;
                else if (sense.rect_low)
                  tx_dat_q <= CE_UP;
                else
                  tx_dat_q <= CE_HOLD;
              end
            end
          L_EPT:
          begin
            out_en_q <= 1'b0;
            if (!tx_busy)
              link_q <= L_DONE;
          end
          L_DONE:
            out_en_q <= 1'b0;
          default:
            link_q <= L_IDLE;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // biphase modulator: 4 slots of 11 bits, preamble then hdr, data, checksum
  // ---------------------------------------------------------------
  logic [$clog2(HALF_BIT_CYCLES)-1:0] half_cnt_q;
  logic second_half_q;
  logic [3:0] bit_pos_q;
  logic [1:0] slot_q;
  logic [7:0] cur_byte;
  logic cur_bit, half_end;
  assign tx_busy = tx_go_q || tx_act_q;
  assign half_end = (half_cnt_q == ($clog2(HALF_BIT_CYCLES))'(HALF_BIT_CYCLES - 1));
  always_comb
  begin
    case (slot_q)
      2'h1: cur_byte = tx_hdr_q;
      2'h2: cur_byte = tx_dat_q;
      default: cur_byte = tx_hdr_q ^ tx_dat_q;
    endcase
    if (slot_q == 2'h0 || bit_pos_q == 4'ha)
      cur_bit = 1'b1;
    else if (bit_pos_q == 4'h0)
      cur_bit = 1'b0;
    else if (bit_pos_q == 4'h9)
      cur_bit = ~^cur_byte;
    else
      cur_bit = cur_byte[bit_pos_q[2:0] - 3'h1];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_act_q <= 1'b0;
      half_cnt_q <= '0;
      second_half_q <= 1'b0;
      bit_pos_q <= 4'h0;
      slot_q <= 2'h0;
      mod_out <= 1'b0;
    end
    else if (tx_go_q)
    begin
      tx_act_q <= 1'b1;
      half_cnt_q <= '0;
      second_half_q <= 1'b0;
      bit_pos_q <= 4'h0;
      slot_q <= 2'h0;
      mod_out <= ~mod_out;
    end
    else if (tx_act_q)
    begin
      half_cnt_q <= half_end ? '0 : half_cnt_q + 1'b1;
      if (half_end)
      begin
        second_half_q <= ~second_half_q;
        if (!second_half_q)
        begin
          if (cur_bit)
            mod_out <= ~mod_out;
        end
        else if (bit_pos_q == 4'(BITS_PER_SLOT - 1) && slot_q == 2'(SLOTS - 1))
        begin
          tx_act_q <= 1'b0;
          mod_out <= 1'b0;
        end
        else
        begin
          // every bit opens with a transition
          mod_out <= ~mod_out;
          bit_pos_q <= (bit_pos_q == 4'(BITS_PER_SLOT - 1)) ? 4'h0 : bit_pos_q + 4'h1;
          if (bit_pos_q == 4'(BITS_PER_SLOT - 1))
            slot_q <= slot_q + 2'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // charge phase sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    phase_d = phase_q;
    if (!out_en_q || !sense.ts_ok || inhibit_q)
      phase_d = P_SUSP;
    else
      case (phase_q)
        P_TERM: phase_d = P_TERM;
        default:
          if (sense.bat_short)
            phase_d = P_SHORT;
          else if (sense.bat_low)
            phase_d = P_PRE;
          else if (sense.bat_reg || phase_q == P_CV)
            phase_d = sense.i_term ? P_TERM : P_CV;
          else
            phase_d = P_FAST;
      endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      phase_q <= P_SUSP;
    else
      phase_q <= phase_d;
  end

  // ---------------------------------------------------------------
  // analog drive and indicator
  // ---------------------------------------------------------------
  logic zone_half;
  assign zone_half = sense.ts_z12 || sense.ts_z34;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      drive <= '0;
      chg_out <= 1'b0;
      chg_oe <= 1'b0;
    end
    else
    begin
      drive.out_en <= out_en_q;
      drive.pass_off <= sense.ovp;
      drive.hiz <= phase_q == P_TERM;
      drive.cur_reduce <= sense.die_hot && phase_q != P_SUSP && phase_q != P_TERM;
      case (phase_q)
        P_SHORT: drive.cur_sel <= C_SHORT;
        P_PRE: drive.cur_sel <= C_PRE;
        P_FAST, P_CV: drive.cur_sel <= zone_half ? C_HALF : C_FULL;
        default: drive.cur_sel <= C_OFF;
      endcase
      drive.vcap <= sense.ts_z34 ? V_410 : (sense.ts_z23 ? V_425 : V_NORM);
      if (link_q == L_RAMP)
        drive.rect_mode <= R_7V;
      else if (sense.bat_low || sense.ovp || (phase_q == P_CV && sense.i_taper35))
        drive.rect_mode <= R_FIXED;
      else
        drive.rect_mode <= R_TRACK;
      chg_oe <= out_en_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_first_packet: assert property ($rose(link_q == L_SS) |-> tx_go_q && tx_hdr_q == HDR_SS)
    else $error("first packet not signal strength");
  chk_startup_order: assert property (link_q == L_CFG && $past(link_q) == L_SS |-> tx_hdr_q == HDR_CFG)
    else $error("configuration not second");
  chk_shutdown_ept: assert property (link_q == L_IDLE && sense.ping && sense.ctrl_high
    && !sense.ad_present && !sense.src_off |=> link_q == L_EPT && tx_dat_q == EPT_CTRL_HIGH)
    else $error("startup shutdown not honoured");
  chk_out_after_7v: assert property ($rose(out_en_q) |-> $past(sense.rect_7v))
    else $error("output enabled below 7 V");
  chk_precharge_cur: assert property (phase_q == P_PRE |=> drive.cur_sel == C_PRE)
    else $error("precharge current wrong");
  chk_term_hiz: assert property (phase_q == P_TERM && out_en_q && sense.ts_ok && !inhibit_q
    |=> drive.hiz && phase_q == P_TERM)
    else $error("terminated output not high impedance");
  chk_zone_half: assert property (phase_q == P_FAST && sense.ts_z12 |=> drive.cur_sel == C_HALF)
    else $error("zone one current not halved");
  chk_full_no_end: assert property (tx_go_q && tx_hdr_q == HDR_FULL |=> link_q == L_MAIN || !sense.ping)
    else $error("full status ended transfer");
  chk_ovp_pass: assert property (sense.ovp |=> drive.pass_off)
    else $error("pass transistor left on in overvoltage");
  chk_ce_spacing: assert property (ce_sent && link_q == L_MAIN |-> $past(ce_ms_q) >= 8'(CE_FAST_MS))
    else $error("error packets too close");
  chk_chg_follow: assert property ($rose(out_en_q) |=> chg_oe ##1 chg_oe || !out_en_q)
    else $error("charging indicator not following output");
  chk_thermal_cut: assert property (sense.die_hot && phase_q == P_FAST |=> drive.cur_reduce)
    else $error("hot die did not reduce current");
  cov_main_loop: cover property (link_q == L_RAMP ##1 link_q == L_MAIN);
  cov_full_sent: cover property (tx_go_q && tx_hdr_q == HDR_FULL);
  cov_ept_sent: cover property (link_q == L_EPT ##1 link_q == L_DONE);
  cov_taper_end: cover property (phase_q == P_CV ##1 phase_q == P_TERM);
endmodule
`default_nettype wire

// >>> testbench/rxc_tx_model.sv
// transmitter side model that decodes load modulation frames
`default_nettype none
module rxc_tx_model
#(
  parameter int HALF = 4
)(
  input wire logic clock,
  input wire logic mod_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] pkt_q[$];
  logic [43:0] bits;
  logic a;
  // one bit per two half bits; a mid-bit change marks a one
  always
  begin
    @(posedge clock iff mod_out === 1'b1);
    for (int k = 0; k < 44; k++)
    begin
      repeat (HALF / 2) @(posedge clock);
      a = mod_out;
      repeat (HALF) @(posedge clock);
      bits[k] = a ^ mod_out;
      repeat (HALF - HALF / 2) @(posedge clock);
    end
    pkt_q.push_back({bits[19:12], bits[30:23]});
  end
endmodule
`default_nettype wire

// >>> testbench/rxc_top_tb.sv
// self-checking bench of the receiver charge controller
`default_nettype none
module rxc_top_tb;
  import rxc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rdata;
  rxc_sense_type sense = '0;
  rxc_sense_type b;
  rxc_drive_type drive;
  logic [15:0] full_ohms;
  logic mod_out;
  logic chg_oe;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 clock = ~clock;
  rxc_top #(.HALF_BIT_CYCLES(4), .MS_CYCLES(8), .PRE_TIMEOUT(8)) u_rxc_top (.clock(clock), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sense_in(sense),
    .drive(drive), .full_ohms(full_ohms), .mod_out(mod_out), .chg_in(!chg_oe), .chg_out(), .chg_oe(chg_oe));
  rxc_tx_model #(.HALF(4)) u_rxc_tx_model (.clock(clock), .mod_out(mod_out));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // error packets, of the ramp as well as of the main loop, are skipped unless one is wanted
  task automatic pkt(input logic [15:0] exp);
    logic [15:0] p;
    do
    begin
      wait (u_rxc_tx_model.pkt_q.size() > 0);
      p = u_rxc_tx_model.pkt_q.pop_front();
    end
    while (p[15:8] === HDR_CE && exp[15:8] !== HDR_CE);
    chk(p, exp);
  endtask
  function automatic logic [15:0] ex(input logic h, input logic r, input rxc_cur_type c,
    input rxc_vcap_type v, input rxc_rect_type m, input logic [5:0] p);
    return {1'b0, h, r, c, v, m, p};
  endfunction
  // sense needs four edges to pass its filter, ten leaves margin
  task automatic step(input logic [15:0] e, input logic [15:0] m);
    logic [15:0] d;
    @(posedge clock);
    sense <= b;
    repeat (10) @(posedge clock);
    rd(REG_PHASE, d);
    chk({1'b0, drive.hiz, drive.cur_reduce, drive.cur_sel, drive.vcap, drive.rect_mode, d[5:0]} & m, e);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] d;
    rd(REG_CTRL, d);
    chk(d, 16'h000a);
    rd(REG_FULL_OHMS, d);
    chk(d, 16'h0960);
    wr(REG_CTRL, 16'h0019);
    wr(REG_FULL_OHMS, 16'h1234);
    rd(REG_FULL_OHMS, d);
    chk(d, 16'h1770);
    chk(full_ohms, 16'h1770);
    rd(4'h9, d);
    chk(d, 16'h0000);
  endtask
  // a shutdown cause at ping ends the transfer before any handshake
  task automatic t_refuse;
    logic [15:0] t [5] = '{16'h0200, 16'h0200, 16'h0201, 16'h0202, 16'h0203};
    for (int i = 0; i < 5; i++)
    begin
      b = '0;
      b.ts_ok = 1'b1;
      b.ping = 1'b1;
      b.src_off = (i == 0);
      b.ad_present = (i == 1);
      b.ctrl_high = (i == 2);
      b.die_fault = (i == 3);
      b.ctrl_low = (i == 4);
      @(posedge clock);
      sense <= b;
      pkt(t[i]);
      sense <= '0;
      repeat (20) @(posedge clock);
    end
  endtask
  task automatic t_start;
    logic [15:0] d;
    b = '0;
    b.ts_ok = 1'b1;
    b.ping = 1'b1;
    sense <= b;
    pkt({HDR_SS, SS_VALUE});
    pkt({HDR_CFG, CFG_VALUE});
    pkt({HDR_ID, ID_VALUE});
    pkt({HDR_CE, CE_UP});
    chk({14'h0, drive.rect_mode}, {14'h0, R_7V});
    chk({15'h0, drive.out_en | chg_oe}, 16'h0000);
    b.rect_7v = 1'b1;
    sense <= b;
    for (int i = 0; i < 800 && drive.out_en !== 1'b1; i++) @(posedge clock);
    chk({14'h0, drive.out_en, chg_oe}, 16'h0003);
    repeat (4) @(posedge clock);
    rd(REG_PHASE, d);
    chk({15'h0, d[6]}, 16'h0000);
  endtask
  task automatic t_phase;
    b.bat_low = 1'b1;
    b.bat_short = 1'b1;
    step(ex(0, 0, C_SHORT, V_NORM, R_FIXED, 6'h01), 16'h7fff);
    b.bat_short = 1'b0;
    step(ex(0, 0, C_PRE, V_NORM, R_FIXED, 6'h02), 16'h7fff);
    b.bat_low = 1'b0;
    step(ex(0, 0, C_FULL, V_NORM, R_TRACK, 6'h04), 16'h7fff);
    b.ts_z12 = 1'b1;
    step(ex(0, 0, C_HALF, V_NORM, R_TRACK, 6'h04), 16'h7fff);
    b.ts_z12 = 1'b0;
    b.ts_z34 = 1'b1;
    step(ex(0, 0, C_HALF, V_410, R_TRACK, 6'h04), 16'h7fff);
    b.ts_z34 = 1'b0;
    b.ts_z23 = 1'b1;
    step(ex(0, 0, C_FULL, V_425, R_TRACK, 6'h04), 16'h7fff);
    b.ts_z23 = 1'b0;
    b.die_hot = 1'b1;
    step(ex(0, 1, C_FULL, V_NORM, R_TRACK, 6'h04), 16'h7fff);
    b.die_hot = 1'b0;
    b.bat_reg = 1'b1;
    b.i_taper35 = 1'b1;
    step(ex(0, 0, C_FULL, V_NORM, R_FIXED, 6'h08), 16'h7fff);
    b.ts_ok = 1'b0;
    step(16'h0020, 16'h003f);
    wr(REG_CTRL, 16'h0099);
    b.ts_ok = 1'b1;
    step(16'h0020, 16'h003f);
    wr(REG_CTRL, 16'h0019);
    b.i_full = 1'b1;
    step(16'h0008, 16'h003f);
    pkt({HDR_FULL, FULL_VALUE});
    chk({15'h0, drive.out_en}, 16'h0001);
    b.ovp = 1'b1;
    step(16'h0008, 16'h003f);
    chk({15'h0, drive.pass_off}, 16'h0001);
    pkt({HDR_CE, CE_DOWN_MAX});
    b.ovp = 1'b0;
    b.i_term = 1'b1;
    step(ex(1, 0, C_OFF, V_NORM, R_TRACK, 6'h10), 16'h7fff);
    b.ad_present = 1'b1;
    @(posedge clock);
    sense <= b;
    pkt({HDR_EPT, EPT_WIRED});
  endtask
  // contracts ending on their own: no convergence, then precharge stuck
  task automatic t_end;
    logic [15:0] d;
    logic [7:0] r;
    for (int i = 0; i < 2; i++)
    begin
      r = i ? EPT_PRE_TIMEOUT : EPT_NO_CONVERGE;
      @(posedge clock);
      sense <= '0;
      repeat (20) @(posedge clock);
      b = '0;
      b.ping = 1'b1;
      b.ts_ok = 1'b1;
      b.rect_7v = i[0];
      b.bat_low = i[0];
      sense <= b;
      pkt({HDR_SS, SS_VALUE});
      pkt({HDR_CFG, CFG_VALUE});
      pkt({HDR_ID, ID_VALUE});
      pkt({HDR_EPT, r});
      rd(REG_LINK, d);
      chk(d, {r, 8'h80});
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_refuse();
    t_start();
    t_phase();
    t_end();
    stop_test();
  end
endmodule
`default_nettype wire
